// >>> logic/rcso_top.v
// Reset cause and system options register bank with APB access
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ns
`include "rcso_regs.vh"

// Overview of operation
// - Reset cause register is read-only and reports the latest reset source.
// - Debug forced reset command clears every reset cause flag.
// - Any write to reset cause address clears the watchdog, flags unchanged.
// - At reset entry flags of active sources set, others cleared; low supply reset sets only brownout and keeps power-on.
// - Power-on flag is bit 7; power-on sets it and the brownout flag.
// - External line flag bit 6 set by low level on external reset input.
// - Watchdog flag bit 5 set on timeout; no timeout reset while disabled.
// - Bad opcode flag bit 4 set after illegal or unimplemented opcode.
// - Halt instruction with halt mode disabled is a bad opcode reset.
// - Debug entry instruction with debug mode disabled is a bad opcode reset.
// - Bad access flag bit 3 set after access to unimplemented address.
// - Brownout flag bit 1 set after low supply reset or power-on.
// - Bits 2 and 0 of reset cause always read zero.
// - Options register takes only the first write after reset; always readable.
// - Reset sets watchdog enable and long timeout; halt and timer routes cleared.
// - Debug pin enable is 1 after power-on, else follows security state.
// - Mode select low during reset forces debug pin enable to 1.
// - Watchdog enable 0 disables the watchdog; 1 forces reset on timeout.
// - Timeout select 0 picks short period, 1 picks long period.
// - Short timeout is 32 ticks, long is 256 ticks of 1 kHz.
// - Halt enable 1 permits halt; 0 turns halt into a bad opcode reset.
// - Reset line enable is 0 after power-on and kept over other resets.
// - Debug pin enable may only be written from 1 to 0.
module rcso_top #(
	parameter integer WDOG_TICK_CYCLES = `RCSO_WDOG_TICK_CYCLES
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        por_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        ext_reset_n,
	input  wire        low_supply_trip,
	input  wire        brownout_reset_enable,
	input  wire        illegal_opcode_evt,
	input  wire        halt_instr_evt,
	input  wire        debug_entry_evt,
	input  wire        debug_mode_enable,
	input  wire        bad_access_evt,
	input  wire        debug_forced_reset_cmd,
	input  wire        mode_select_line,
	input  wire        security_disengaged,
	output reg         sys_reset_req_r,
	output reg         halt_grant_r,
	output reg         watchdog_enable,
	output reg         watchdog_timeout_select,
	output reg         halt_mode_enable,
	output reg         timer_ch1_route,
	output reg         timer_ch0_route,
	output reg         debug_pin_enable,
	output reg         reset_line_enable
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	reg  [7:0] reset_cause_reg;
	reg        opts_written_r;
	reg        por_pending_r;
	reg        dbg_pin_init_r;
	reg        post_reset_r;
	reg        wdog_clear_r;
	wire       wdog_timeout;
	wire       acc;
	wire       wr_fire;
	wire       hit_cause;
	wire       hit_opts;
	wire       opts_wr;
	wire       src_ext;
	wire       src_wdog;
	wire       src_opcode;
	wire       src_access;
	wire       src_lvr;
	wire       any_src;
	wire [7:0] system_options_reg;
	wire [7:0] cause_nxt;

	// Aligned word decode shared by read and write paths
	function is_reg;
		input [11:0] addr;
		input [11:0] off;
		begin
			is_reg = (addr[11:2] == off[11:2]);
		end
	endfunction

	// ****************************************************************
	// APB decode
	// ****************************************************************
	// One wait state: pready is a flop so the answer always comes at the second access edge
	assign acc       = psel && penable;
	assign wr_fire   = acc && pready && pwrite;
	assign hit_cause = is_reg(paddr, `RCSO_OFF_RESET_CAUSE);
	assign hit_opts  = is_reg(paddr, `RCSO_OFF_SYS_OPTIONS);
	assign opts_wr   = wr_fire && hit_opts && !opts_written_r;

	assign system_options_reg = {watchdog_enable, watchdog_timeout_select, halt_mode_enable,
		1'b0, timer_ch1_route, timer_ch0_route, debug_pin_enable, reset_line_enable};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (acc && !pready) begin
			pready  <= 1'b1;
			pslverr <= !(hit_cause || hit_opts);
			if (!pwrite && hit_cause) begin
				prdata <= {24'h00_0000, reset_cause_reg & `RCSO_RC_IMPL_MASK};
			end else if (!pwrite && hit_opts) begin
				prdata <= {24'h00_0000, system_options_reg};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
	end

	// ****************************************************************
	// Watchdog
	// ****************************************************************
	// A write to the cause address and the first options write both restart the count
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdog_clear_r <= 1'b0;
		end else begin
			wdog_clear_r <= (wr_fire && hit_cause) || opts_wr;
		end
	end

	rcso_wdog #(
		.TICK_CYCLES (WDOG_TICK_CYCLES)
	) u_wdog (
		.pclk        (pclk),
		.presetn     (presetn),
		.enable      (watchdog_enable),
		.long_sel    (watchdog_timeout_select),
		.clear       (wdog_clear_r),
		.timeout_r   (wdog_timeout)
	);

	// ****************************************************************
	// Reset sources
	// ****************************************************************
	assign src_ext    = reset_line_enable && !ext_reset_n;
	assign src_wdog   = wdog_timeout && watchdog_enable;
	assign src_opcode = illegal_opcode_evt
		|| (halt_instr_evt && !halt_mode_enable)
		|| (debug_entry_evt && !debug_mode_enable);
	assign src_access = bad_access_evt;
	assign src_lvr    = low_supply_trip && brownout_reset_enable;
	assign any_src    = src_ext || src_wdog || src_opcode || src_access || src_lvr
		|| debug_forced_reset_cmd;

	// Low supply reset keeps the power-on flag and masks the others
	assign cause_nxt = debug_forced_reset_cmd ? 8'h00 :
		src_lvr ? {reset_cause_reg[`RCSO_RC_POWER_ON], 5'h00, 1'b1, 1'b0} :
		{1'b0, src_ext, src_wdog, src_opcode, src_access, 3'h0};

	// ****************************************************************
	// Reset cause capture (power-on domain)
	// ****************************************************************
	// Lives outside the system reset so the cause survives the reset it records
	always @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			reset_cause_reg <= `RCSO_RC_POR_VALUE;
			sys_reset_req_r <= 1'b0;
		end else begin
			sys_reset_req_r <= any_src;
			if (any_src && !sys_reset_req_r) begin
				reset_cause_reg <= cause_nxt;
			end
		end
	end

	// ****************************************************************
	// Debug pin reset value (power-on domain)
	// ****************************************************************
	// Straps are sampled while system reset is held, then loaded at release
	always @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			por_pending_r  <= 1'b1;
			dbg_pin_init_r <= 1'b1;
		end else if (!presetn) begin
			dbg_pin_init_r <= por_pending_r || !mode_select_line || security_disengaged;
		end else begin
			por_pending_r <= 1'b0;
		end
	end

	// ****************************************************************
	// Reset line enable (power-on domain)
	// ****************************************************************
	always @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			reset_line_enable <= 1'b0;
		end else if (opts_wr) begin
			reset_line_enable <= pwdata[`RCSO_OPT_RST_LINE];
		end
	end

	// ****************************************************************
	// System options (system reset domain)
	// ****************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog_enable         <= 1'b1;
			watchdog_timeout_select <= 1'b1;
			halt_mode_enable        <= 1'b0;
			timer_ch1_route         <= 1'b0;
			timer_ch0_route         <= 1'b0;
			debug_pin_enable        <= 1'b1;
			opts_written_r          <= 1'b0;
			post_reset_r            <= 1'b1;
		end else begin
			post_reset_r <= 1'b0;
			if (opts_wr) begin
				watchdog_enable         <= pwdata[`RCSO_OPT_WDOG_EN];
				watchdog_timeout_select <= pwdata[`RCSO_OPT_WDOG_LONG];
				halt_mode_enable        <= pwdata[`RCSO_OPT_HALT_EN];
				timer_ch1_route         <= pwdata[`RCSO_OPT_TMR_CH1];
				timer_ch0_route         <= pwdata[`RCSO_OPT_TMR_CH0];
				debug_pin_enable        <= debug_pin_enable && pwdata[`RCSO_OPT_DBG_PIN];
				opts_written_r          <= 1'b1;
			end else if (post_reset_r) begin
				debug_pin_enable <= dbg_pin_init_r;
			end
		end
	end

	// ****************************************************************
	// Halt grant
	// ****************************************************************
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_grant_r <= 1'b0;
		end else begin
			halt_grant_r <= halt_instr_evt && halt_mode_enable;
		end
	end

endmodule // rcso_top

// >>> shared/rcso_regs.vh
// Offsets, field positions, reset values and timing counts of the reset cause and options block
`ifndef RCSO_REGS_VH
`define RCSO_REGS_VH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define RCSO_OFF_RESET_CAUSE    12'h000
`define RCSO_OFF_SYS_OPTIONS    12'h004

// ****************************************************************
// Reset cause field positions
// ****************************************************************
`define RCSO_RC_POWER_ON        7
`define RCSO_RC_EXT_LINE        6
`define RCSO_RC_WATCHDOG        5
`define RCSO_RC_BAD_OPCODE      4
`define RCSO_RC_BAD_ACCESS      3
`define RCSO_RC_BROWNOUT        1
`define RCSO_RC_IMPL_MASK       8'hfa
`define RCSO_RC_POR_VALUE       8'h82

// ****************************************************************
// System options field positions and reset values
// ****************************************************************
`define RCSO_OPT_WDOG_EN        7
`define RCSO_OPT_WDOG_LONG      6
`define RCSO_OPT_HALT_EN        5
`define RCSO_OPT_TMR_CH1        3
`define RCSO_OPT_TMR_CH0        2
`define RCSO_OPT_DBG_PIN        1
`define RCSO_OPT_RST_LINE       0
`define RCSO_OPT_IMPL_MASK      8'hef
`define RCSO_OPT_RESET_VALUE    8'hc2

// ****************************************************************
// Watchdog timing
// ****************************************************************
`define RCSO_PCLK_PERIOD_NS     10
`define RCSO_WDOG_TICK_NS       1000000
`define RCSO_WDOG_TICK_CYCLES   (`RCSO_WDOG_TICK_NS / `RCSO_PCLK_PERIOD_NS)
`define RCSO_WDOG_SHORT_TICKS   32
`define RCSO_WDOG_LONG_TICKS    256

`endif

// >>> logic/rcso_wdog.v
// Watchdog timeout counter driven by a divided 1 kHz tick enable
`timescale 1ns/1ns
`include "rcso_regs.vh"

module rcso_wdog #(
	parameter integer TICK_CYCLES = `RCSO_WDOG_TICK_CYCLES
) (
	input  wire pclk,
	input  wire presetn,
	input  wire enable,
	input  wire long_sel,
	input  wire clear,
	output reg  timeout_r
);

	// ****************************************************************
	// Tick divider
	// ****************************************************************
	reg  [31:0] div_r;
	reg  [8:0]  cnt_r;
	wire        tick;
	wire [8:0]  limit;

	assign tick  = (div_r == TICK_CYCLES - 1);
	assign limit = long_sel ? 9'h100 : 9'h020;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 32'h0000_0000;
		end else if (clear || tick) begin
			div_r <= 32'h0000_0000;
		end else begin
			div_r <= div_r + 32'h0000_0001;
		end
	end

	// ****************************************************************
	// Overflow counter
	// ****************************************************************
	// Disabled watchdog holds at zero so no stale count survives re-enabling
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r     <= 9'h000;
			timeout_r <= 1'b0;
		end else if (clear || !enable) begin
			cnt_r     <= 9'h000;
			timeout_r <= 1'b0;
		end else begin
			timeout_r <= 1'b0;
			if (tick) begin
				if (cnt_r + 9'h001 >= limit) begin
					cnt_r     <= 9'h000;
					timeout_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 9'h001;
				end
			end
		end
	end

endmodule // rcso_wdog

// >>> dv/rcso_props.sv
// Port level assertions for the reset cause and options block
`timescale 1ns/1ns
module rcso_props (
	input wire        pclk,
	input wire        presetn,
	input wire        por_n,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        halt_instr_evt,
	input wire        bad_access_evt,
	input wire        sys_reset_req_r,
	input wire        halt_grant_r,
	input wire        watchdog_enable,
	input wire        watchdog_timeout_select,
	input wire        halt_mode_enable,
	input wire        timer_ch1_route,
	input wire        timer_ch0_route,
	input wire        debug_pin_enable,
	input wire        reset_line_enable
);
	// ****
	// Helpers and checks
	// ****
	reg        locked_r;
	wire [5:0] opt_w = {watchdog_enable, watchdog_timeout_select, halt_mode_enable,
		timer_ch1_route, timer_ch0_route, debug_pin_enable};
	wire       opt_wr = pready && pwrite && paddr == 12'h004;
	// Marks that the one honoured options write has happened
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			locked_r <= 1'b0;
		else if (opt_wr)
			locked_r <= 1'b1;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wait_state_a: assert property ($rose(penable) && psel |=> pready ##1 !pready)
		else $error("pready late or not a pulse");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits set");
	rc_gaps_a: assert property (pready && !pwrite && paddr == 12'h000 |-> !prdata[2] && !prdata[0])
		else $error("unused cause bits set");
	bad_addr_a: assert property (pready |->
		pslverr == (paddr[11:2] != 10'h000 && paddr[11:2] != 10'h001))
		else $error("error response wrong");
	write_once_a: assert property (locked_r && opt_wr |=> $stable(opt_w))
		else $error("second options write took effect");
	opt_reset_a: assert property ($rose(presetn) |-> opt_w[5:1] == 5'b11000)
		else $error("options reset value wrong");
	pin_one_way_a: assert property (!debug_pin_enable |=> !debug_pin_enable)
		else $error("debug pin enable rose");
	halt_grant_a: assert property (halt_grant_r == $past(halt_instr_evt && halt_mode_enable))
		else $error("halt grant wrong");
	entry_req_a: assert property (disable iff (!por_n) bad_access_evt && !sys_reset_req_r |=> sys_reset_req_r)
		else $error("no reset request");
	line_por_a: assert property (disable iff (!por_n) $rose(por_n) |-> !reset_line_enable)
		else $error("reset line enable set after power-on");
	cover property (opt_wr && locked_r);
	cover property (pready && pslverr);
	cover property ($rose(sys_reset_req_r));
endmodule // rcso_props

bind rcso_top rcso_props u_rcso_props (
	.pclk                    (pclk),
	.presetn                 (presetn),
	.por_n                   (por_n),
	.psel                    (psel),
	.penable                 (penable),
	.pwrite                  (pwrite),
	.paddr                   (paddr),
	.prdata                  (prdata),
	.pready                  (pready),
	.pslverr                 (pslverr),
	.halt_instr_evt          (halt_instr_evt),
	.bad_access_evt          (bad_access_evt),
	.sys_reset_req_r         (sys_reset_req_r),
	.halt_grant_r            (halt_grant_r),
	.watchdog_enable         (watchdog_enable),
	.watchdog_timeout_select (watchdog_timeout_select),
	.halt_mode_enable        (halt_mode_enable),
	.timer_ch1_route         (timer_ch1_route),
	.timer_ch0_route         (timer_ch0_route),
	.debug_pin_enable        (debug_pin_enable),
	.reset_line_enable       (reset_line_enable)
);

// >>> dv/testbench.sv
// Self-checking bench for the reset cause and options block
`timescale 1ns/1ns
module testbench;
	reg         pclk, presetn, por_n, psel, penable, pwrite, bre, dme, ms, sd, dbg, err;
	reg  [11:0] paddr;
	reg  [31:0] pwdata, rd, rnd;
	wire [6:0]  opt_pins;
	reg  [7:0]  src, v;
	wire [31:0] prdata;
	wire        pready, pslverr, sys_reset_req_r, halt_grant_r;
	integer     errors, total_checks, i, n;

	rcso_top #(.WDOG_TICK_CYCLES(4)) u_rcso_top (
		.pclk(pclk),
		.presetn(presetn),
		.por_n(por_n),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.sys_reset_req_r(sys_reset_req_r),
		.halt_grant_r(halt_grant_r),
		.ext_reset_n(!src[0]),
		.bad_access_evt(src[1]),
		.illegal_opcode_evt(src[2]),
		.halt_instr_evt(src[3]),
		.debug_entry_evt(src[4]),
		.low_supply_trip(src[6]),
		.debug_forced_reset_cmd(src[7]),
		.brownout_reset_enable(bre),
		.debug_mode_enable(dme),
		.mode_select_line(ms),
		.security_disengaged(sd),
		.watchdog_enable(opt_pins[6]),
		.watchdog_timeout_select(opt_pins[5]),
		.halt_mode_enable(opt_pins[4]),
		.timer_ch1_route(opt_pins[3]),
		.timer_ch0_route(opt_pins[2]),
		.debug_pin_enable(opt_pins[1]),
		.reset_line_enable(opt_pins[0])
	);

	// ****
	// Tasks
	// ****
	function [7:0] cause(input integer k);
		case (k)
			0: cause = 8'h40;
			1: cause = 8'h08;
			5: cause = 8'h20;
			6: cause = 8'h02;
			7: cause = 8'h00;
			8: cause = 8'h82;
			default: cause = 8'h10;
		endcase
	endfunction
	task chk(input [31:0] g, input [31:0] e);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				errors = errors + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1) begin
				@(posedge pclk);
			end
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	// Straps change only while reset is held, as the device samples them then
	task rst(input p);
		begin
			@(posedge pclk);
			presetn <= 1'b0;
			por_n <= !p;
			rnd = $urandom;
			ms <= rnd[0];
			sd <= rnd[1];
			repeat (6) @(posedge pclk);
			presetn <= 1'b1;
			por_n <= 1'b1;
			dbg = p | !ms | sd;
		end
	endtask
	task report_and_stop;
		begin
			$display("checks=%0d errors=%0d", total_checks, errors);
			if (errors == 0 && total_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask

	// ****
	// Sequence
	// ****
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#200000;
		errors = errors + 1;
		report_and_stop;
	end
	initial begin
		{presetn, por_n, psel, penable, pwrite, bre, dme, ms, sd} = 9'h000;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		src = 8'h00;
		errors = 0;
		total_checks = 0;
		rnd = $urandom(32'h3a9d);
		rst(1);
		apb(0, 12'h000, 0);
		chk(rd, 8'h82);
		apb(0, 12'h004, 0);
		chk(rd, 8'hc2);
		apb(1, 12'h000, $urandom);
		apb(0, 12'h000, 0);
		chk(rd, 8'h82);
		apb(0, 12'h008, 0);
		chk(err, 1);
		// Watchdog off, halt allowed, reset line on, the rest random
		rnd = $urandom;
		v = (rnd[7:0] & 8'h4f) | 8'h21;
		apb(1, 12'h004, v);
		apb(1, 12'h004, {24'h000000, ~v});
		apb(0, 12'h004, 0);
		chk(rd, v);
		chk({opt_pins[6:4], 1'b0, opt_pins[3:0]}, v);
		@(posedge pclk);
		src[3] <= 1'b1;
		@(posedge pclk);
		src[3] <= 1'b0;
		#1 chk({halt_grant_r, sys_reset_req_r}, 2'b10);
		n = 0;
		repeat (1100) begin
			@(posedge pclk);
			n = n + sys_reset_req_r;
		end
		chk(n, 0);
		for (i = 0; i < 9; i = i + 1) begin
			rst(0);
			apb(0, 12'h000, 0);
			chk(rd, cause(i == 0 ? 8 : i - 1));
			apb(0, 12'h004, 0);
			chk(rd, {2'b11, 4'h0, dbg, 1'b1});
			chk({opt_pins[6:4], 1'b0, opt_pins[3:0]}, {2'b11, 4'h0, dbg, 1'b1});
			if (i < 8) begin
				v = (i == 5) ? 8'h83 : 8'h03;
				apb(1, 12'h004, v);
				apb(0, 12'h004, 0);
				chk(rd, {v[7], 5'h00, dbg, 1'b1});
				chk({opt_pins[6:4], 1'b0, opt_pins[3:0]}, {v[7], 5'h00, dbg, 1'b1});
				rnd = $urandom;
				bre <= rnd[0] | (i == 6);
				dme <= rnd[1] & (i != 4);
				src[i] <= (i != 5);
				n = 0;
				while (sys_reset_req_r !== 1'b1 && n < 400) begin
					@(posedge pclk);
					n = n + 1;
				end
				chk(sys_reset_req_r, 1);
				if (i == 5) chk(n > 100 && n < 150, 1);
				src <= 8'h00;
			end
		end
		report_and_stop;
	end
endmodule // testbench
